//--- flash_host.sv
// Host controller that drives an asynchronous boot-block flash through its pins.
//
// Behaviour
// - Erase is setup code then confirm code as next write, with supply high.
// - Program is setup code then the data write at the target address.
// - After program or erase, read-array code or a reset pulse comes before any array read.
// - Programming supply is held high during every confirm and data write.
// - Boot block confirm or data needs unlock voltage on reset pin or protect high.
// - High-voltage identification drives all other address bits but bit 0 low.
`timescale 1ns/100ps
module flash_host (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input flash_host_pkg::host_req_t cmd,
    output logic rsp_valid,
    output logic [15:0] rdata,
    output flash_host_pkg::flash_ctrl_t ctrl,
    output logic [17:0] addr,
    output logic [15:0] dq_out,
    output logic [15:0] dq_oe,
    input wire logic [15:0] dq_in
);
    flash_host_pkg::bus_state_t state;
    flash_host_pkg::host_req_t req;
    flash_host_pkg::bus_op_t cur;
    logic req_stale;
    logic stale;
    logic hold_hv;
    logic hold_wp;
    logic [1:0] step;
    logic [7:0] prev_code;
    logic timer_load;
    logic [3:0] timer_val;
    logic expired;
    logic active;
    logic finishing;

    // The bus operation for the current step of the latched request.
    always_comb begin
        cur = '0;
        cur.last = 1'b1;
        unique case (req.op)
            flash_host_pkg::OP_READ: begin
                if (req_stale && step == 2'd0) begin
                    cur.data = {8'h00, flash_host_pkg::CMD_READ_ARRAY};
                    cur.last = 1'b0;
                end else begin
                    cur.is_read = 1'b1;
                end
            end
            flash_host_pkg::OP_PROGRAM: begin
                if (step == 2'd0) begin
                    cur.data = {8'h00, flash_host_pkg::CMD_PROG_SETUP};
                    cur.last = 1'b0;
                end else begin
                    cur.data = req.wdata;
                    cur.supply = 1'b1;
                end
            end
            flash_host_pkg::OP_ERASE: begin
                if (step == 2'd0) begin
                    cur.data = {8'h00, flash_host_pkg::CMD_ERASE_SETUP};
                    cur.last = 1'b0;
                end else begin
                    cur.data = {8'h00, flash_host_pkg::CMD_ERASE_CONFIRM};
                    cur.supply = 1'b1;
                end
            end
            flash_host_pkg::OP_READ_ARRAY: begin
                cur.data = {8'h00, flash_host_pkg::CMD_READ_ARRAY};
            end
            flash_host_pkg::OP_ID_CMD: begin
                if (step == 2'd0) begin
                    cur.data = {8'h00, flash_host_pkg::CMD_IDENTIFY};
                    cur.last = 1'b0;
                end else begin
                    cur.is_read = 1'b1;
                    cur.id_read = 1'b1;
                end
            end
            flash_host_pkg::OP_ID_HV: begin
                cur.is_read = 1'b1;
                cur.id_read = 1'b1;
                cur.hv_id = 1'b1;
            end
            default: begin
                cur.last = 1'b1;
            end
        endcase
    end

    assign active = (state == flash_host_pkg::ST_SETUP) || (state == flash_host_pkg::ST_STROBE)
        || (state == flash_host_pkg::ST_HOLD);
    assign finishing = (state == flash_host_pkg::ST_HOLD) && cur.last;
    assign cmd_ready = (state == flash_host_pkg::ST_IDLE);
    assign timer_load = (state == flash_host_pkg::ST_SETUP)
        || (cmd_valid && cmd_ready && cmd.op == flash_host_pkg::OP_RESET);
    assign timer_val = (state != flash_host_pkg::ST_SETUP) ? flash_host_pkg::RESET_LOAD
        : (cur.is_read ? flash_host_pkg::ACCESS_LOAD : flash_host_pkg::WE_LOAD);

    phase_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .load(timer_load),
        .load_val(timer_val),
        .expired(expired)
    );

    // Bus cycle sequencer.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= flash_host_pkg::ST_IDLE;
            step <= 2'd0;
        end else begin
            unique case (state)
                flash_host_pkg::ST_IDLE: begin
                    step <= 2'd0;
                    if (cmd_valid) begin
                        state <= (cmd.op == flash_host_pkg::OP_RESET) ? flash_host_pkg::ST_RESET
                            : flash_host_pkg::ST_SETUP;
                    end
                end
                flash_host_pkg::ST_SETUP: state <= flash_host_pkg::ST_STROBE;
                flash_host_pkg::ST_STROBE: begin
                    if (expired) begin
                        state <= flash_host_pkg::ST_HOLD;
                    end
                end
                flash_host_pkg::ST_HOLD: begin
                    state <= cur.last ? flash_host_pkg::ST_IDLE : flash_host_pkg::ST_SETUP;
                    step <= step + 2'd1;
                end
                flash_host_pkg::ST_RESET: begin
                    if (expired) begin
                        state <= flash_host_pkg::ST_IDLE;
                    end
                end
                default: state <= flash_host_pkg::ST_IDLE;
            endcase
        end
    end

    // Request latch; stale state at acceptance decides the extra read-array write.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req <= '0;
            req_stale <= 1'b0;
        end else if (cmd_valid && cmd_ready) begin
            req <= cmd;
            req_stale <= stale;
        end
    end

    // The array is stale after program or erase until read-array or reset.
    // Supply and unlock are kept until then because the host cannot see completion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stale <= 1'b0;
            hold_hv <= 1'b0;
            hold_wp <= 1'b0;
        end else if (finishing && cur.supply) begin
            stale <= 1'b1;
            hold_hv <= req.boot && !req.unlock_by_wp;
            hold_wp <= req.boot && req.unlock_by_wp;
        end else if ((state == flash_host_pkg::ST_HOLD && !cur.is_read
            && cur.data[7:0] == flash_host_pkg::CMD_READ_ARRAY && !cur.supply)
            || state == flash_host_pkg::ST_RESET) begin
            stale <= 1'b0;
            hold_hv <= 1'b0;
            hold_wp <= 1'b0;
        end
    end

    // Address and data lines are registered on the edge that ends a step's setup cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= '0;
            dq_out <= '0;
            dq_oe <= flash_host_pkg::OE_NONE;
        end else if (state == flash_host_pkg::ST_IDLE || state == flash_host_pkg::ST_RESET) begin
            dq_oe <= flash_host_pkg::OE_NONE;
        end else if (state == flash_host_pkg::ST_SETUP) begin
            if (cur.id_read) begin
                addr <= {17'h0, req.addr[0]};
                dq_out <= '0;
                dq_oe <= req.byte_mode ? flash_host_pkg::OE_BYTE_READ : flash_host_pkg::OE_NONE;
            end else if (req.byte_mode) begin
                addr <= req.addr[18:1];
                dq_out <= {req.addr[0], 7'h00, cur.data[7:0]};
                dq_oe <= cur.is_read ? flash_host_pkg::OE_BYTE_READ
                    : flash_host_pkg::OE_BYTE_WRITE;
            end else begin
                addr <= req.addr[17:0];
                dq_out <= cur.data;
                dq_oe <= cur.is_read ? flash_host_pkg::OE_NONE : flash_host_pkg::OE_WORD;
            end
        end
    end

    // Read data is sampled at the end of the access time.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (state == flash_host_pkg::ST_STROBE && expired && cur.is_read) begin
            rdata <= req.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
        end
    end

    assign rsp_valid = finishing;

    always_comb begin
        ctrl.ce_n = !active;
        ctrl.oe_n = !(state == flash_host_pkg::ST_STROBE && cur.is_read);
        ctrl.we_n = !(state == flash_host_pkg::ST_STROBE && !cur.is_read);
        ctrl.reset_powerdown_n = (state != flash_host_pkg::ST_RESET);
        ctrl.boot_unlock_voltage = hold_hv
            || (active && cur.supply && req.boot && !req.unlock_by_wp);
        ctrl.wp = hold_wp || (active && cur.supply && req.boot && req.unlock_by_wp);
        ctrl.byte_n = !req.byte_mode;
        ctrl.vpp_high = stale || (active && cur.supply);
        ctrl.id_voltage = active && cur.hv_id;
    end

    // Low byte of the last write, command or data, kept for checking sequence order.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_code <= 8'h00;
        end else if (state == flash_host_pkg::ST_HOLD && !cur.is_read) begin
            prev_code <= cur.data[7:0];
        end
    end

    strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(!ctrl.oe_n && !ctrl.we_n))
        else $error("both strobes low");
    strobe_select_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!ctrl.we_n || !ctrl.oe_n) |-> !ctrl.ce_n && ctrl.reset_powerdown_n)
        else $error("strobe without chip select");
    erase_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == flash_host_pkg::ST_HOLD && req.op == flash_host_pkg::OP_ERASE && cur.last)
        |-> prev_code == flash_host_pkg::CMD_ERASE_SETUP
            && dq_out[7:0] == flash_host_pkg::CMD_ERASE_CONFIRM)
        else $error("erase confirm not after setup");
    program_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == flash_host_pkg::ST_HOLD && req.op == flash_host_pkg::OP_PROGRAM && cur.last)
        |-> prev_code == flash_host_pkg::CMD_PROG_SETUP)
        else $error("program data not after setup");
    supply_held_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!ctrl.we_n && cur.supply) |-> ctrl.vpp_high ##1 ctrl.vpp_high)
        else $error("supply low at confirm");
    boot_unlock_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!ctrl.we_n && cur.supply && req.boot) |-> ctrl.boot_unlock_voltage || ctrl.wp)
        else $error("boot write without unlock");
    array_fresh_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!ctrl.oe_n && !cur.id_read) |-> !stale)
        else $error("array read before read-array code");
    id_address_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ctrl.id_voltage && !ctrl.oe_n) |-> addr[17:1] == 17'h0)
        else $error("address not low in id read");
    byte_float_a: assert property (@(posedge clk) disable iff (!rst_b)
        (active && req.byte_mode) |-> dq_oe[14:8] == 7'h00)
        else $error("upper lines driven in byte mode");
    reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(ctrl.reset_powerdown_n) |-> (!ctrl.reset_powerdown_n && dq_oe == 16'h0000)[*3]
            ##1 ctrl.reset_powerdown_n)
        else $error("reset pulse length wrong");
    write_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(ctrl.we_n) |-> (!ctrl.we_n)[*2] ##1 ctrl.we_n)
        else $error("write pulse length wrong");

    erase_done_c: cover property (@(posedge clk) disable iff (!rst_b)
        finishing && req.op == flash_host_pkg::OP_ERASE);
    program_boot_c: cover property (@(posedge clk) disable iff (!rst_b)
        finishing && req.op == flash_host_pkg::OP_PROGRAM && req.boot);
    stale_read_c: cover property (@(posedge clk) disable iff (!rst_b)
        finishing && req.op == flash_host_pkg::OP_READ && req_stale);
    id_hv_c: cover property (@(posedge clk) disable iff (!rst_b)
        finishing && req.op == flash_host_pkg::OP_ID_HV && req.byte_mode);
endmodule : flash_host

//--- flash_host_pkg.sv
// Shared constants, operation codes and carrier types for the flash bus host.
package flash_host_pkg;

    localparam int ADDR_W = 18;
    localparam int DQ_W = 16;

    // Bus codes written to the flash data lines.
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_IDENTIFY = 8'h90;

    // Output enables on the data lines for each bus shape.
    localparam logic [15:0] OE_WORD = 16'hffff;
    localparam logic [15:0] OE_BYTE_WRITE = 16'h80ff;
    localparam logic [15:0] OE_BYTE_READ = 16'h8000;
    localparam logic [15:0] OE_NONE = 16'h0000;

    // Timing, at a 40 ns clock.
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_ACCESS_NS = 80;
    localparam int T_WE_PULSE_NS = 60;
    localparam int T_RESET_LOW_NS = 100;
    localparam int ACCESS_CYCLES = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_CYCLES = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYCLES = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ACCESS_LOAD = 4'(ACCESS_CYCLES - 1);
    localparam logic [3:0] WE_LOAD = 4'(WE_CYCLES - 1);
    localparam logic [3:0] RESET_LOAD = 4'(RESET_CYCLES - 1);

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE = 3'h2,
        OP_READ_ARRAY = 3'h3,
        OP_ID_CMD = 3'h4,
        OP_ID_HV = 3'h5,
        OP_RESET = 3'h6
    } host_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b010,
        ST_RESET = 3'b110
    } bus_state_t;

    typedef struct packed {
        host_op_t op;
        logic [18:0] addr;
        logic [15:0] wdata;
        logic byte_mode;
        logic boot;
        logic unlock_by_wp;
    } host_req_t;

    typedef struct packed {
        logic is_read;
        logic [15:0] data;
        logic hv_id;
        logic id_read;
        logic supply;
        logic last;
    } bus_op_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_powerdown_n;
        logic boot_unlock_voltage;
        logic wp;
        logic byte_n;
        logic vpp_high;
        logic id_voltage;
    } flash_ctrl_t;

endpackage : flash_host_pkg

//--- phase_timer.sv
// Down counter that times the strobe phase of a flash bus cycle and the reset pulse.
`timescale 1ns/100ps
module phase_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [3:0] load_val,
    output logic expired
);
    logic [3:0] count;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 4'h0;
        end else if (load) begin
            count <= load_val;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign expired = (count == 4'h0);
endmodule : phase_timer

//--- flash_model.sv
// Behavioural flash device that answers the host controller at its pins.
`timescale 1ns/100ps
module flash_model #(
    parameter logic [7:0] MAKER_LO = 8'h5a, // Identification values are arbitrary.
    parameter logic [7:0] MAKER_HI = 8'h11,
    parameter logic [7:0] DEV_LO = 8'h3c,
    parameter logic [7:0] DEV_HI = 8'ha6
) (
    input wire logic clk,
    input flash_host_pkg::flash_ctrl_t ctrl,
    input wire logic [17:0] addr,
    input wire logic [15:0] dq_oe,
    input wire logic [15:0] dq,
    output logic [15:0] dq_drv,
    output int n_prog,
    output int n_erase,
    output int n_bad,
    output int n_viol
);
    logic [15:0] mem [int];
    logic [1:0] pend = 2'h0;
    logic id_mode = 1'b0;
    logic stat_mode = 1'b0;
    logic flip = 1'b0;
    logic rd;
    logic [15:0] val, en, wr;
    int key;
    initial begin
        n_prog = 0;
        n_erase = 0;
        n_bad = 0;
        n_viol = 0;
    end
    // Released lines toggle every cycle so a stale value is never mistaken for data.
    always @(posedge clk) flip <= ~flip;
    assign rd = ctrl.reset_powerdown_n && !ctrl.ce_n && !ctrl.oe_n && ctrl.we_n;
    always_comb begin
        key = ctrl.byte_n ? int'(addr) : int'({1'b1, addr, dq[15]});
        if (id_mode || ctrl.id_voltage) begin
            val = addr[0] ? {DEV_HI, DEV_LO} : {MAKER_HI, MAKER_LO};
        end else if (stat_mode) begin
            val = 16'h0080;
        end else begin
            val = mem.exists(key) ? mem[key] : 16'hffff;
        end
        en = !rd ? 16'h0000 : (ctrl.byte_n ? 16'hffff : 16'h00ff);
        dq_drv = (val & en) | (~en & {16{flip}});
    end
    always @(posedge ctrl.we_n or negedge ctrl.reset_powerdown_n) begin
        wr = ctrl.byte_n ? dq : {8'h00, dq[7:0]};
        if (!ctrl.reset_powerdown_n) begin
            pend = 2'h0;
            id_mode = 1'b0;
            stat_mode = 1'b0;
        end else if (!ctrl.ce_n) begin
            if (pend != 2'h0) begin
                if (!ctrl.vpp_high || (addr < 18'h02000 && !(ctrl.boot_unlock_voltage || ctrl.wp))) begin
                    n_bad++;
                end else if (pend == 2'h1 && wr[7:0] == flash_host_pkg::CMD_ERASE_CONFIRM) begin
                    n_erase++;
                end else if (pend == 2'h2) begin
                    mem[key] = wr;
                    n_prog++;
                end else begin
                    n_bad++;
                end
                stat_mode = 1'b1;
                pend = 2'h0;
            end else begin
                case (wr[7:0])
                    flash_host_pkg::CMD_ERASE_SETUP: pend = 2'h1;
                    flash_host_pkg::CMD_PROG_SETUP, flash_host_pkg::CMD_PROG_SETUP_ALT: pend = 2'h2;
                    flash_host_pkg::CMD_IDENTIFY: id_mode = 1'b1;
                    flash_host_pkg::CMD_READ_ARRAY: begin
                        id_mode = 1'b0;
                        stat_mode = 1'b0;
                    end
                    default: n_bad++;
                endcase
            end
        end
    end
    always @(posedge clk) begin
        if (rd && ((dq_oe & en) != 16'h0000 || (ctrl.id_voltage && (addr & 18'h3fdfe) != 18'h0) ||
                (!ctrl.byte_n && !dq_oe[15]))) begin
            n_viol++;
        end
    end
endmodule : flash_model

//--- flash_host_test.sv
// Self-checking bench for the flash host controller against a device model.
`timescale 1ns/100ps
module flash_host_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    flash_host_pkg::host_req_t cmd = '0;
    logic cmd_ready, rsp_valid;
    logic [15:0] rdata, dq_out, dq_oe, dq_in, dq_drv;
    logic [17:0] addr;
    flash_host_pkg::flash_ctrl_t ctrl;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_prog, n_erase, n_bad, n_viol, lo, lat;
    always #20 clk = ~clk;
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & dq_drv);
    flash_host dut_u (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rdata(rdata), .ctrl(ctrl), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    flash_model model_u (.clk(clk), .ctrl(ctrl), .addr(addr), .dq_oe(dq_oe), .dq(dq_in),
        .dq_drv(dq_drv), .n_prog(n_prog), .n_erase(n_erase), .n_bad(n_bad), .n_viol(n_viol));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // One request; returns at the falling edge of its completion cycle.
    task automatic run(input flash_host_pkg::host_op_t op, input logic [18:0] a,
            input logic [15:0] d, input logic bm, input logic boot, input logic wp);
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) check(n, 0);
        cmd = '{op, a, d, bm, boot, wp};
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        lo = 0;
        n = 0;
        while (n < 20 && !(rsp_valid === 1'b1 ||
                (op == flash_host_pkg::OP_RESET && cmd_ready === 1'b1))) begin
            if (ctrl.reset_powerdown_n === 1'b0) lo++;
            @(negedge clk);
            n++;
        end
        lat = n;
        if (n >= 20) check(n, 0);
    endtask : run
    task automatic t_words;
        run(flash_host_pkg::OP_PROGRAM, 19'h04321, 16'hbeef, 1'b0, 1'b0, 1'b0);
        check(n_prog, 1);
        check(ctrl.vpp_high, 1'b1);
        check(lat, 7);
        run(flash_host_pkg::OP_PROGRAM, 19'h04322, 16'h1234, 1'b0, 1'b0, 1'b0);
        run(flash_host_pkg::OP_READ, 19'h04321, 16'h0000, 1'b0, 1'b0, 1'b0);
        check(rdata, 16'hbeef);
        check(ctrl.vpp_high, 1'b0);
        run(flash_host_pkg::OP_READ, 19'h04322, 16'h0000, 1'b0, 1'b0, 1'b0);
        check(rdata, 16'h1234);
        check(lat, 3);
    endtask : t_words
    task automatic t_boot;
        for (int wp = 0; wp < 2; wp++) begin
            run(flash_host_pkg::OP_ERASE, 19'h00100, 16'h0000, 1'b0, 1'b1, wp[0]);
            check(n_erase, wp + 1);
            check({ctrl.boot_unlock_voltage, ctrl.wp}, wp[0] ? 2'b01 : 2'b10);
            run(flash_host_pkg::OP_PROGRAM, 19'h00101, 16'h0f0f, 1'b1, 1'b1, wp[0]);
            run(flash_host_pkg::OP_READ_ARRAY, 19'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
        end
        run(flash_host_pkg::OP_READ, 19'h00101, 16'h0000, 1'b1, 1'b1, 1'b0);
        check(rdata, 16'h000f);
        check(n_bad, 0);
    endtask : t_boot
    task automatic t_ident;
        logic [15:0] exp;
        for (int k = 0; k < 8; k++) begin
            // Leave command identify mode so the high-voltage reads stand on their own.
            if (k == 4) run(flash_host_pkg::OP_READ_ARRAY, 19'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
            exp = k[0] ? 16'ha63c : 16'h115a;
            if (k[1]) exp[15:8] = 8'h00;
            run(k[2] ? flash_host_pkg::OP_ID_HV : flash_host_pkg::OP_ID_CMD,
                k[1] ? 19'(k[0] * 3) : 19'(k[0]), 16'h0000, k[1], 1'b0, 1'b0);
            check(rdata, exp);
        end
        run(flash_host_pkg::OP_READ_ARRAY, 19'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
        run(flash_host_pkg::OP_READ, 19'h04321, 16'h0000, 1'b0, 1'b0, 1'b0);
        check(rdata, 16'hbeef);
    endtask : t_ident
    task automatic t_reset_op;
        run(flash_host_pkg::OP_PROGRAM, 19'h05000, 16'h7e81, 1'b0, 1'b0, 1'b0);
        run(flash_host_pkg::OP_RESET, 19'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
        check(lo, flash_host_pkg::RESET_CYCLES);
        check({ctrl.vpp_high, dq_oe}, 17'h00000);
        run(flash_host_pkg::OP_READ, 19'h05000, 16'h0000, 1'b0, 1'b0, 1'b0);
        check(rdata, 16'h7e81);
    endtask : t_reset_op
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        check({ctrl.ce_n, ctrl.reset_powerdown_n, ctrl.vpp_high, cmd_ready, dq_oe}, 20'hd0000);
        rst_b = 1'b1;
        @(negedge clk);
        t_words();
        t_boot();
        t_ident();
        t_reset_op();
        check(n_viol, 0);
        check(n_bad, 0);
        test_done();
    end
endmodule : flash_host_test
